//--- rtl/led_ctrl_map.svh
// Constants for the LED driver mode and fault control block.
// Assumes inclusion by bare name from rtl files; definitions only.
//
// Contract
// - Shutdown after clock-low timeout in active modes
// - Timeout resets activate, mode, fixed voltage
// - Protection trip sets readable fault flag
// - Fault register read clears all flags
// - Any fault forces activate and mode off
// - Soft ramp; pause upward ramp out of regulation
// - Force fixed frequency under listed conditions
// - Indicator mode always uses pulse skip
// - Near max duty may drop to 1 MHz
// - Dual frequency off selects pulse skip
// - Flash timeout programmable 2 to 1280 ms; code takes any 10-bit limit, up to 1023 steps (2046 ms)
// - Host chooses mode; device applies it
// - Each sink uses its own level
// - Mode codes; activate low means standby
// - First clock high clears timeout counter
`ifndef LED_CTRL_MAP_SVH
`define LED_CTRL_MAP_SVH

// ****************************************
// Encodings and timing
// ****************************************
`define MODE_STANDBY     2'h0
`define MODE_INDICATOR   2'h1
`define MODE_ASSIST      2'h2
`define MODE_FLASH       2'h3
`define LEVEL_FORCE_MIN  8'h40
`define FAULT_W          4
`define CLK_SYS_KHZ      25000
`define LINK_CLK_KHZ     4000
`define TIMEOUT_MS       100
`define TIMEOUT_CYC      (`TIMEOUT_MS * `LINK_CLK_KHZ)
`define FLASH_STEP_MS    2
`define FLASH_STEP_CYC   (`FLASH_STEP_MS * `CLK_SYS_KHZ)
`define FLASH_MAX_STEPS  640
`define RAMP_UP_US       250
`define RAMP_STEP_CYC    ((`RAMP_UP_US * `CLK_SYS_KHZ) / (1000 * 256))

`endif

//--- rtl/led_ctrl_pkg.sv
// Types shared by the LED driver control files.
// Assumes nothing beyond a SystemVerilog compiler.
package led_ctrl_pkg;
	typedef enum {ST_OFF, ST_UP, ST_ON, ST_DOWN} ramp_state_t;
	typedef enum {SW_PULSE_SKIP, SW_FIXED_4M, SW_FIXED_1M} switch_mode_t;
endpackage

//--- rtl/scl_timeout.sv
// Clock-low watchdog running on the internal oscillator domain.
// Assumes scl_in raw from the pin; arm is synchronised here, expiry crosses to clk_sys outside.
`timescale 1ns/100ps
`include "led_ctrl_map.svh"
module scl_timeout #(
	parameter int TIMEOUT_CYC = `TIMEOUT_CYC
) (
	input  wire logic clk_osc,
	input  wire logic rst_n,
	input  wire logic scl_in,
	input  wire logic arm_in,
	output logic      expired_toggle
);
	typedef struct packed {
		logic        scl_meta;
		logic        scl_sync;
		logic        arm_meta;
		logic        arm_sync;
		logic [31:0] count;
		logic        fired;
		logic        toggle;
	} wd_t;
	wd_t wd_reg;
	wd_t wd_next;

	// Count only while clock low; any high restarts at once
	always_comb begin
		wd_next          = wd_reg;
		wd_next.scl_meta = scl_in;
		wd_next.scl_sync = wd_reg.scl_meta;
		wd_next.arm_meta = arm_in;
		wd_next.arm_sync = wd_reg.arm_meta;
		if (wd_reg.scl_sync) begin
			wd_next.count = 32'h0;
			wd_next.fired = 1'b0;
		end else if (wd_reg.arm_sync && !wd_reg.fired) begin
			wd_next.count = wd_reg.count + 32'h1;
			if (wd_reg.count >= 32'(TIMEOUT_CYC - 1)) begin
				wd_next.fired  = 1'b1;
				wd_next.toggle = ~wd_reg.toggle;
			end
		end else if (!wd_reg.arm_sync) begin
			wd_next.count = 32'h0;
		end
	end

	always_ff @(posedge clk_osc or negedge rst_n) begin
		if (!rst_n) begin
			wd_reg <= '0;
		end else begin
			wd_reg <= wd_next;
		end
	end

	assign expired_toggle = wd_reg.toggle;
endmodule // scl_timeout

//--- rtl/led_ctrl.sv
// Mode, fault, ramp and switching control of the LED flash driver.
// Assumes host writes arrive as one-cycle strobes on clk_sys; faults are
// same-domain pulses; scl_in and strobe_in are raw pins.
`timescale 1ns/100ps
`include "led_ctrl_map.svh"
module led_ctrl #(
	parameter int TIMEOUT_CYC    = `TIMEOUT_CYC,
	parameter int FLASH_STEP_CYC = `FLASH_STEP_CYC,
	parameter int RAMP_STEP_CYC  = `RAMP_STEP_CYC,
	parameter int FAULT_W        = `FAULT_W
) (
	input  wire logic               clk_sys,
	input  wire logic               clk_osc,
	input  wire logic               rst_n,
	input  wire logic               scl_in,
	input  wire logic               strobe_in,
	input  wire logic               ctrl_wr,
	input  wire logic               activate_wr,
	input  wire logic [1:0]         mode_wr,
	input  wire logic               fixed_voltage_wr,
	input  wire logic               dual_freq_wr,
	input  wire logic               high_range_wr,
	input  wire logic               strobe_on_wr,
	input  wire logic               level_wr,
	input  wire logic [7:0]         sink1_level_wr,
	input  wire logic [7:0]         sink2_level_wr,
	input  wire logic               timeout_wr,
	input  wire logic [9:0]         strobe_limit_time_wr,
	input  wire logic [FAULT_W-1:0] fault_event,
	input  wire logic               fault_rd,
	input  wire logic               in_regulation,
	input  wire logic               near_max_duty,
	output logic                    output_activate,
	output logic [1:0]              operating_select,
	output logic                    fixed_voltage_select,
	output logic [FAULT_W-1:0]      fault_flags,
	output logic                    timeout_fault,
	output logic [7:0]              sink1_drive,
	output logic [7:0]              sink2_drive,
	output logic                    sinks_on,
	output logic                    fixed_freq,
	output logic                    freq_1m,
	output logic                    pulse_skip,
	output logic                    shutdown
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic                       activate;
		logic [1:0]                 mode;
		logic                       fixed_v;
		logic                       dual_freq;
		logic                       high_range;
		logic                       strobe_on;
		logic [7:0]                 lvl1;
		logic [7:0]                 lvl2;
		logic [9:0]                 limit;
		logic [FAULT_W-1:0]         faults;
		logic                       tmo_fault;
		logic                       shut;
		logic                       arm;
		logic [2:0]                 exp_sync;
		logic                       strobe_meta;
		logic                       strobe_sync;
		logic [31:0]                step_cnt;
		logic [9:0]                 steps;
		logic [31:0]                ramp_cnt;
		logic [7:0]                 ramp;
		led_ctrl_pkg::ramp_state_t  rstate;
		led_ctrl_pkg::switch_mode_t smode;
		logic [7:0]                 d1;
		logic [7:0]                 d2;
		logic                       sinks;
	} st_t;
	st_t s_reg;
	st_t s_next;
	logic expired_toggle;

	// Watchdog on oscillator domain; result returns as a toggle
	scl_timeout #(
		.TIMEOUT_CYC(TIMEOUT_CYC)
	) u_wd (
		.clk_osc        (clk_osc),
		.rst_n          (rst_n),
		.scl_in         (scl_in),
		.arm_in         (s_reg.arm),
		.expired_toggle (expired_toggle)
	);

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb begin
		logic active;
		logic expired;
		logic any_fault;
		logic flashing;
		logic [7:0] target;
		active    = 1'b0;
		expired   = 1'b0;
		any_fault = 1'b0;
		flashing  = 1'b0;
		target    = 8'h0;
		s_next    = s_reg;

		// Pin and watchdog crossings
		s_next.exp_sync    = {s_reg.exp_sync[1:0], expired_toggle};
		s_next.strobe_meta = strobe_in;
		s_next.strobe_sync = s_reg.strobe_meta;
		expired = s_reg.exp_sync[2] ^ s_reg.exp_sync[1];

		// Host writes, applied as given
		if (ctrl_wr) begin
			s_next.activate   = activate_wr;
			s_next.mode       = mode_wr;
			s_next.fixed_v    = fixed_voltage_wr;
			s_next.dual_freq  = dual_freq_wr;
			s_next.high_range = high_range_wr;
			s_next.strobe_on  = strobe_on_wr;
			s_next.shut       = 1'b0;
		end
		if (level_wr) begin
			s_next.lvl1 = sink1_level_wr;
			s_next.lvl2 = sink2_level_wr;
		end
		if (timeout_wr) begin
			s_next.limit = strobe_limit_time_wr;
		end

		// Flash duration counter, 2 ms per step
		flashing = s_reg.activate && (s_reg.mode == `MODE_FLASH);
		if (!flashing) begin
			s_next.step_cnt = 32'h0;
			s_next.steps    = 10'h0;
		end else if (s_reg.step_cnt >= 32'(FLASH_STEP_CYC - 1)) begin
			s_next.step_cnt = 32'h0;
			s_next.steps    = s_reg.steps + 10'h1;
		end else begin
			s_next.step_cnt = s_reg.step_cnt + 32'h1;
		end
		if (flashing && (s_reg.steps >= s_reg.limit)) begin
			// Any flash that overran ends and sets the timeout flag unless fault_rd clears it that cycle; a strobe-held one also raises any_fault
			if (s_reg.strobe_on && s_reg.strobe_sync) begin
				any_fault = 1'b1;
			end
			s_next.tmo_fault = 1'b1;
			s_next.activate  = 1'b0;
			s_next.mode      = `MODE_STANDBY;
		end

		// Sticky faults: read clears, same-cycle fault_event survives, a same-cycle flash overrun flag does not
		if (fault_rd) begin
			s_next.faults    = '0;
			s_next.tmo_fault = 1'b0;
		end
		if (|fault_event) begin
			s_next.faults = (fault_rd ? '0 : s_reg.faults) | fault_event;
			any_fault     = 1'b1;
		end
		if (any_fault) begin
			s_next.activate = 1'b0;
			s_next.mode     = `MODE_STANDBY;
		end

		// Clock-low expiry clears activate, mode and fixed voltage
		if (expired && s_reg.arm) begin
			s_next.activate = 1'b0;
			s_next.mode     = `MODE_STANDBY;
			s_next.fixed_v  = 1'b0;
			s_next.shut     = 1'b1;
		end

		// Watchdog armed only in a lit, nonstandby mode
		active     = s_reg.activate && (s_reg.mode != `MODE_STANDBY);
		s_next.arm = active;

		// Soft ramp in 1/256 steps of the setting
		target = active ? 8'hFF : 8'h0;
		if (s_reg.ramp_cnt >= 32'(RAMP_STEP_CYC - 1)) begin
			s_next.ramp_cnt = 32'h0;
		end else begin
			s_next.ramp_cnt = s_reg.ramp_cnt + 32'h1;
		end
		case (s_reg.rstate)
			led_ctrl_pkg::ST_OFF: begin
				if (active) s_next.rstate = led_ctrl_pkg::ST_UP;
			end
			led_ctrl_pkg::ST_UP: begin
				if (!active) begin
					s_next.rstate = led_ctrl_pkg::ST_DOWN;
				end else if (s_reg.ramp == target) begin
					s_next.rstate = led_ctrl_pkg::ST_ON;
				end else if (in_regulation && s_reg.ramp_cnt == 32'h0) begin
					s_next.ramp = s_reg.ramp + 8'h1;
				end
			end
			led_ctrl_pkg::ST_ON: begin
				if (!active) s_next.rstate = led_ctrl_pkg::ST_DOWN;
			end
			led_ctrl_pkg::ST_DOWN: begin
				if (active) begin
					s_next.rstate = led_ctrl_pkg::ST_UP;
				end else if (s_reg.ramp == 8'h0) begin
					s_next.rstate = led_ctrl_pkg::ST_OFF;
				end else if (s_reg.ramp_cnt == 32'h0) begin
					s_next.ramp = s_reg.ramp - 8'h1;
				end
			end
			default: s_next.rstate = led_ctrl_pkg::ST_OFF;
		endcase
		// Sink drive: mode masks the setting, then scaled by (ramp + 1) / 256
		// Full ramp gives the exact setting; zero ramp still gives zero
		s_next.sinks = (s_reg.ramp != 8'h0);
		case (s_reg.mode)
			`MODE_INDICATOR: begin
				s_next.d1 = 8'((16'(s_reg.lvl1 & 8'h3F) * s_reg.ramp
					+ 16'(s_reg.lvl1 & 8'h3F)) >> 8);
				s_next.d2 = 8'((16'(s_reg.lvl2 & 8'h3F) * s_reg.ramp
					+ 16'(s_reg.lvl2 & 8'h3F)) >> 8);
			end
			`MODE_ASSIST: begin
				s_next.d1 = 8'((16'(s_reg.lvl1 & 8'h7F) * s_reg.ramp
					+ 16'(s_reg.lvl1 & 8'h7F)) >> 8);
				s_next.d2 = 8'((16'(s_reg.lvl2 & 8'h7F) * s_reg.ramp
					+ 16'(s_reg.lvl2 & 8'h7F)) >> 8);
			end
			default: begin
				s_next.d1 = 8'((16'(s_reg.lvl1) * s_reg.ramp + 16'(s_reg.lvl1)) >> 8);
				s_next.d2 = 8'((16'(s_reg.lvl2) * s_reg.ramp + 16'(s_reg.lvl2)) >> 8);
			end
		endcase
		if (!active && s_reg.rstate == led_ctrl_pkg::ST_OFF) begin
			s_next.d1 = 8'h0;
			s_next.d2 = 8'h0;
		end

		// Switching scheme selection
		if (!s_reg.dual_freq || s_reg.mode == `MODE_INDICATOR || !active) begin
			s_next.smode = led_ctrl_pkg::SW_PULSE_SKIP;
		end else if (s_reg.lvl1 >= `LEVEL_FORCE_MIN && s_reg.lvl2 >= `LEVEL_FORCE_MIN
			&& !s_reg.high_range && s_reg.rstate != led_ctrl_pkg::ST_UP) begin
			// Forced fixed; startup takes the same fixed choice in the branches below
			s_next.smode = near_max_duty ? led_ctrl_pkg::SW_FIXED_1M
				: led_ctrl_pkg::SW_FIXED_4M;
		end else if (near_max_duty) begin
			s_next.smode = led_ctrl_pkg::SW_FIXED_1M;
		end else begin
			s_next.smode = led_ctrl_pkg::SW_FIXED_4M;
		end
	end

	// Single register stage for all state
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// ****************************************
	// Outputs from flip-flops; switching flags decoded from smode
	// ****************************************
	assign output_activate      = s_reg.activate;
	assign operating_select     = s_reg.mode;
	assign fixed_voltage_select = s_reg.fixed_v;
	assign fault_flags          = s_reg.faults;
	assign timeout_fault        = s_reg.tmo_fault;
	assign sink1_drive          = s_reg.d1;
	assign sink2_drive          = s_reg.d2;
	assign sinks_on             = s_reg.sinks;
	assign fixed_freq           = (s_reg.smode != led_ctrl_pkg::SW_PULSE_SKIP);
	assign freq_1m              = (s_reg.smode == led_ctrl_pkg::SW_FIXED_1M);
	assign pulse_skip           = (s_reg.smode == led_ctrl_pkg::SW_PULSE_SKIP);
	assign shutdown             = s_reg.shut;
endmodule // led_ctrl

//--- bench/host_scl_model.sv
// Host side of the serial clock line, as seen by the driver.
// Assumes clk_osc from the bench; scl_mode chosen by the bench.
`timescale 1ns/100ps
module host_scl_model (
	input  wire logic       clk_osc,
	input  wire logic [1:0] scl_mode,
	output logic            scl_in
);
	logic [5:0] cnt_reg = 6'h00;
	// Free phase counter; low phase stays short of the limit
	always @(posedge clk_osc) begin
		cnt_reg <= (cnt_reg == 6'h2F) ? 6'h00 : cnt_reg + 6'h01;
	end
	// 0 idle high, 1 held low (host gone), 2 slow clocking
	assign scl_in = (scl_mode == 2'h0) || (scl_mode == 2'h2 && cnt_reg >= 6'h28);
endmodule // host_scl_model

//--- bench/led_ctrl_props.sv
// Port-level checker for led_ctrl fault, mode, switching and ramp.
// Assumes bind onto led_ctrl; all checks on clk_sys.
`timescale 1ns/100ps
module led_ctrl_props #(parameter int FAULT_W = 4) (
	input wire logic               clk_sys,
	input wire logic               clk_osc,
	input wire logic               rst_n,
	input wire logic               ctrl_wr,
	input wire logic               activate_wr,
	input wire logic [1:0]         mode_wr,
	input wire logic [FAULT_W-1:0] fault_event,
	input wire logic               fault_rd,
	input wire logic               in_regulation,
	input wire logic               output_activate,
	input wire logic [1:0]         operating_select,
	input wire logic               fixed_voltage_select,
	input wire logic [FAULT_W-1:0] fault_flags,
	input wire logic [7:0]         sink1_drive,
	input wire logic               freq_1m,
	input wire logic               pulse_skip,
	input wire logic               shutdown
);
	// ****************************************
	// Properties
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	AST_FAULT_OFF: assert property (|fault_event |=> !output_activate && operating_select == 2'h0)
		else $error("fault left output on");
	AST_FAULT_SET: assert property (|fault_event |=> (fault_flags & $past(fault_event)) == $past(fault_event))
		else $error("fault flag not set");
	AST_READ_CLR: assert property (fault_rd && !(|fault_event) |=> fault_flags == '0)
		else $error("read did not clear flags");
	AST_READ_KEEP: assert property (fault_rd && |fault_event |=> fault_flags == $past(fault_event))
		else $error("event lost at read");
	AST_CTRL_LOAD: assert property (ctrl_wr && !(|fault_event) |=>
		operating_select == $past(mode_wr) && output_activate == $past(activate_wr))
		else $error("mode write not applied");
	AST_IND_SKIP: assert property ((output_activate && operating_select == 2'h1) [*2] |-> pulse_skip)
		else $error("indicator without pulse skip");
	AST_LOW_FREQ: assert property (freq_1m |-> (output_activate && operating_select[1]) ||
		$past(output_activate && operating_select[1]))
		else $error("1 MHz outside flash or assist");
	AST_SHUTDOWN: assert property ($rose(shutdown) |-> !output_activate && operating_select == 2'h0
		&& !fixed_voltage_select)
		else $error("shutdown kept settings");
	AST_RAMP_HOLD: assert property (!in_regulation [*2] |-> sink1_drive <= $past(sink1_drive))
		else $error("ramp rose out of regulation");
	// Main scenarios reached
	COV_SHUT: cover property ($rose(shutdown));
	COV_1M: cover property (freq_1m);
	COV_KEEP: cover property (fault_rd && |fault_event);
endmodule // led_ctrl_props
bind led_ctrl led_ctrl_props #(.FAULT_W(FAULT_W)) props_i (.clk_sys(clk_sys), .clk_osc(clk_osc),
	.rst_n(rst_n), .ctrl_wr(ctrl_wr), .activate_wr(activate_wr), .mode_wr(mode_wr),
	.fault_event(fault_event), .fault_rd(fault_rd), .in_regulation(in_regulation),
	.output_activate(output_activate), .operating_select(operating_select),
	.fixed_voltage_select(fixed_voltage_select), .fault_flags(fault_flags),
	.sink1_drive(sink1_drive), .freq_1m(freq_1m), .pulse_skip(pulse_skip), .shutdown(shutdown));

//--- bench/led_ctrl_bench.sv
// Self-checking bench for led_ctrl with shortened counts.
// Assumes led_ctrl_map.svh on the include path.
`timescale 1ns/100ps
`include "led_ctrl_map.svh"
module led_ctrl_bench;
	logic       clk_sys = 0, clk_osc = 0, rst_n = 0, ctrl_wr = 0, level_wr = 0, timeout_wr = 0;
	logic       activate_wr = 0, fixed_voltage_wr = 0, dual_freq_wr = 0, high_range_wr = 0;
	logic       strobe_on_wr = 0, fault_rd = 0, in_regulation = 1, near_max_duty = 0;
	logic [1:0] mode_wr = 0, scl_mode = 0;
	logic [7:0] sink1_level_wr = 0, sink2_level_wr = 0, sink1_drive, sink2_drive;
	logic [9:0] strobe_limit_time_wr = 0;
	logic [3:0] fault_event = 0, fault_flags;
	logic       scl_in, output_activate, fixed_voltage_select, timeout_fault, sinks_on;
	logic       fixed_freq, freq_1m, pulse_skip, shutdown;
	logic [1:0] operating_select;
	int         num_errors = 0, tests_run = 0, n;
	// ****************************************
	// Clocks, partner and device
	// ****************************************
	always #20 clk_sys = ~clk_sys;
	always #62.5 clk_osc = ~clk_osc;
	host_scl_model host (.clk_osc(clk_osc), .scl_mode(scl_mode), .scl_in(scl_in));
	led_ctrl #(.TIMEOUT_CYC(50), .FLASH_STEP_CYC(10), .RAMP_STEP_CYC(1)) uut (
		.clk_sys(clk_sys), .clk_osc(clk_osc), .rst_n(rst_n), .scl_in(scl_in), .strobe_in(1'b0),
		.ctrl_wr(ctrl_wr), .activate_wr(activate_wr), .mode_wr(mode_wr),
		.fixed_voltage_wr(fixed_voltage_wr), .dual_freq_wr(dual_freq_wr),
		.high_range_wr(high_range_wr), .strobe_on_wr(strobe_on_wr), .level_wr(level_wr),
		.sink1_level_wr(sink1_level_wr), .sink2_level_wr(sink2_level_wr), .timeout_wr(timeout_wr),
		.strobe_limit_time_wr(strobe_limit_time_wr), .fault_event(fault_event),
		.fault_rd(fault_rd), .in_regulation(in_regulation), .near_max_duty(near_max_duty),
		.output_activate(output_activate), .operating_select(operating_select),
		.fixed_voltage_select(fixed_voltage_select), .fault_flags(fault_flags),
		.timeout_fault(timeout_fault), .sink1_drive(sink1_drive), .sink2_drive(sink2_drive),
		.sinks_on(sinks_on), .fixed_freq(fixed_freq), .freq_1m(freq_1m),
		.pulse_skip(pulse_skip), .shutdown(shutdown));
	// ****************************************
	// Access tasks
	// ****************************************
	// Inputs move 1 ns after the edge, away from sampling
	task automatic tick(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic ctrl(input logic a, input logic [1:0] m, input logic fv, input logic dual);
		{activate_wr, mode_wr, fixed_voltage_wr, dual_freq_wr} = {a, m, fv, dual};
		ctrl_wr = 1;
		tick(1);
		ctrl_wr = 0;
		tick(1);
	endtask
	task automatic lvl(input logic [7:0] a, input logic [7:0] b);
		{sink1_level_wr, sink2_level_wr, level_wr} = {a, b, 1'b1};
		tick(1);
		level_wr = 0;
	endtask
	// Bounded wait for the output to drop; running out ends the run
	task automatic wait_off(input int lim);
		for (n = 0; n < lim && output_activate !== 1'b0; n++) tick(1);
		if (output_activate !== 1'b0) begin
			num_errors++;
			tally_and_finish();
		end
	endtask
	task automatic tally_and_finish();
		$display("errors=%0d checks=%0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		tick(20);
		rst_n = 1;
		tick(2);
		chk({output_activate, operating_select, fault_flags, pulse_skip}, 16'h0001); // Defaults
		{strobe_limit_time_wr, timeout_wr} = {10'h3FF, 1'b1};
		tick(1);
		timeout_wr = 0;
		for (int m = 1; m < 4; m++) begin
			ctrl(1, m[1:0], 0, 0);
			chk({output_activate, operating_select, pulse_skip}, {13'h0, 1'b1, m[1:0], 1'b1}); // Mode, skip
		end
		ctrl(0, `MODE_FLASH, 0, 1);
		tick(300);
		chk({output_activate, sinks_on}, 16'h0000); // Standby with mode set
		lvl(8'h40, 8'h40);
		ctrl(1, `MODE_FLASH, 0, 1);
		chk({fixed_freq, freq_1m, pulse_skip}, 16'h0004); // Forced fixed
		near_max_duty = 1;
		tick(3);
		chk({fixed_freq, freq_1m, pulse_skip}, 16'h0006); // Max duty
		near_max_duty = 0;
		ctrl(1, `MODE_INDICATOR, 0, 1);
		chk({fixed_freq, freq_1m, pulse_skip}, 16'h0001); // Indicator skips
		lvl(8'h9C, 8'h21);
		ctrl(0, `MODE_FLASH, 0, 1);
		tick(300);
		in_regulation = 0;
		ctrl(1, `MODE_FLASH, 0, 1);
		tick(20);
		chk(sink1_drive, 16'h0000); // Ramp paused
		in_regulation = 1;
		tick(300);
		chk({sink1_drive, sink2_drive}, 16'h9C21); // Own levels
		ctrl(1, `MODE_ASSIST, 0, 1);
		tick(300);
		chk({sink1_drive, sink2_drive}, 16'h1C21); // Seven bits in assist
		fault_event = 4'h5;
		tick(1);
		fault_event = 0;
		chk({fault_flags, output_activate, operating_select}, 16'h0028); // Flags, output off
		{fault_rd, fault_event} = {1'b1, 4'h2};
		tick(1);
		fault_event = 0;
		chk(fault_flags, 16'h0002); // Event kept over read
		tick(1);
		fault_rd = 0;
		chk(fault_flags, 16'h0000); // Read clears
		{strobe_limit_time_wr, timeout_wr} = {10'h003, 1'b1};
		tick(1);
		timeout_wr = 0;
		ctrl(1, `MODE_FLASH, 0, 0);
		wait_off(100);
		chk({n >= 25 && n <= 35, timeout_fault}, 16'h0003); // Flash limit 30 cycles
		ctrl(1, `MODE_INDICATOR, 1, 0);
		scl_mode = 2;
		tick(600);
		chk({shutdown, output_activate}, 16'h0001); // Short lows restart count
		scl_mode = 1;
		wait_off(400);
		chk({shutdown, operating_select, fixed_voltage_select}, 16'h0008); // Clock low
		scl_mode = 0;
		tick(10);
		ctrl(0, `MODE_FLASH, 0, 0);
		chk(operating_select, 16'h0003); // Accepted after wake
		scl_mode = 1;
		tick(600);
		chk(shutdown, 16'h0000); // No shutdown in standby
		tally_and_finish();
	end
endmodule // led_ctrl_bench
